// *** include/fault_sup_pkg.sv ***
// Constants shared by the LED driver fault supervisor.
// Assumes a single 25 MHz core clock.
package fault_sup_pkg;
	localparam int CLK_HZ                = 25000000;
	localparam int EN_LOW_CYCLES         = 32750;
	localparam int GRACE_CYCLES          = 10000;
	localparam int SYNC_LOW_TIME_NS      = 7000;
	localparam int SYNC_LOW_CYCLES       = (SYNC_LOW_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int UV_FALL_TIME_NS       = 50000;
	localparam int UV_FALL_CYCLES        = (UV_FALL_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int SHUT_2X_TIME_NS       = 3000;
	localparam int SHUT_2X_CYCLES        = (SHUT_2X_TIME_NS * (CLK_HZ / 1000000)) / 1000;
	localparam int STARTUP_BLANK_CYCLES  = 64;
	localparam int CNT_W                 = 16;
	localparam int FILT_W                = 12;
endpackage : fault_sup_pkg

// *** src/low_timer.sv ***
// Saturating low-level timer: flags once its input has been low for LIMIT cycles.
// Input must already be synchronised to core_clk.
`timescale 1ns/1ps
module low_timer #(
	parameter int W     = 16,
	parameter int LIMIT = 100
) (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic level_low,
	output logic      expired
);
	logic [W-1:0] cnt_r;

	initial begin
		if (LIMIT < 1 || LIMIT >= (1 << W))
			$error("low_timer LIMIT does not fit W");
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			cnt_r <= '0;
		else if (!level_low)
			cnt_r <= '0;
		else if (cnt_r != W'(LIMIT))
			cnt_r <= cnt_r + W'(1);
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			expired <= 1'b0;
		else
			expired <= level_low && (cnt_r >= W'(LIMIT - 1));
	end
endmodule : low_timer

// *** src/led_driver_fault_supervisor.sv ***
// Fault supervisor for a boost LED driver: current limits, input disconnect, overvoltage, undervoltage, shutdown.
// Analog comparators arrive asynchronous; all are double-registered before use.
//
// Summary of operation
// - Cycle limit blanks boost until next switching cycle
// - Secondary switch limit latches everything off
// - Long enable low releases latched faults
// - 1X input current flags fault, timer runs
// - 1X clears before timeout: flag released
// - Boost, sinks keep running during grace
// - Sync low beyond 7us forces shutdown
// - 2X input current latches shutdown quickly
// - Enable once supply and sense above rise
// - Supply below fall for 50us disables
// - Enable low 32750 cycles: shutdown, clear
// - Enable-low shutdown keeps sources off until enable high
// - Switch node overvoltage latches off
// - Startup blanking suppresses some detections
// - Undervoltage turns all off, clears latches
`timescale 1ns/1ps
module led_driver_fault_supervisor #(
	parameter int EN_LOW_CYCLES = fault_sup_pkg::EN_LOW_CYCLES,
	parameter int GRACE_CYCLES  = fault_sup_pkg::GRACE_CYCLES
) (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic switch_cycle_tick,
	input  wire logic dim_enable_pin,
	input  wire logic freq_set_sync_pin,
	input  wire logic switch_cycle_current_limit,
	input  wire logic secondary_switch_limit,
	input  wire logic input_over_1x,
	input  wire logic input_over_2x,
	input  wire logic secondary_overvoltage_threshold,
	input  wire logic supply_above_rise,
	input  wire logic sense_above_rise,
	input  wire logic supply_below_fall,
	output logic      boost_enable,
	output logic      disconnect_on,
	output logic      disconnect_limit_mode,
	output logic      sinks_enable,
	output logic      fault_n,
	output logic      low_power
);
	localparam int CW = fault_sup_pkg::CNT_W;

	typedef enum logic [1:0] {
		ST_OFF     = 2'b00,
		ST_STARTUP = 2'b01,
		ST_RUN     = 2'b11,
		ST_LATCHED = 2'b10
	} sup_state_type;

	initial begin
		if (EN_LOW_CYCLES < 2 || EN_LOW_CYCLES >= (1 << CW) || GRACE_CYCLES < 2 || GRACE_CYCLES >= (1 << CW))
			$error("count parameters out of range");
	end

	// Two-flop synchronisers for every asynchronous input
	localparam int NS = 10;
	logic [NS-1:0] raw;
	logic [NS-1:0] s1_r;
	logic [NS-1:0] s2_r;
	assign raw = {dim_enable_pin, freq_set_sync_pin, switch_cycle_current_limit, secondary_switch_limit,
		input_over_1x, input_over_2x, secondary_overvoltage_threshold, supply_above_rise,
		sense_above_rise, supply_below_fall};

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= raw;
			s2_r <= s1_r;
		end
	end

	logic en_s, sync_s, cyc_lim_s, sec_lim_s, over1_s, over2_s, ovp_s, vin_ok_s, sense_ok_s, vin_low_s;
	assign {en_s, sync_s, cyc_lim_s, sec_lim_s, over1_s, over2_s, ovp_s, vin_ok_s, sense_ok_s, vin_low_s} = s2_r;

	logic en_low_done, sync_low_done, uv_done;

	low_timer #(.W(CW), .LIMIT(EN_LOW_CYCLES)) u_en_timer (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.level_low (!en_s),
		.expired   (en_low_done)
	);
	low_timer #(.W(CW), .LIMIT(fault_sup_pkg::SYNC_LOW_CYCLES)) u_sync_timer (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.level_low (!sync_s),
		.expired   (sync_low_done)
	);
	low_timer #(.W(fault_sup_pkg::FILT_W), .LIMIT(fault_sup_pkg::UV_FALL_CYCLES)) u_uv_timer (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.level_low (vin_low_s),
		.expired   (uv_done)
	);

	sup_state_type state_r;
	logic          uv_lock_r;
	logic [CW-1:0] grace_r;
	logic [CW-1:0] blank_r;
	logic          cyc_off_r;

	// Undervoltage lockout: filtered fall locks, rise thresholds release
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			uv_lock_r <= 1'b1;
		else if (uv_done)
			uv_lock_r <= 1'b1;
		else if (vin_ok_s && sense_ok_s)
			uv_lock_r <= 1'b0;
	end

	logic blanking;
	logic grace_expired;
	logic hard_fault;
	assign blanking      = (state_r == ST_STARTUP);
	assign grace_expired = (grace_r == CW'(GRACE_CYCLES));
	// Secondary overvoltage is suppressed while the boost is still starting up
	assign hard_fault    = sec_lim_s || over2_s || (ovp_s && !blanking) || grace_expired;

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			state_r <= ST_OFF;
		else if (uv_lock_r)
			state_r <= ST_OFF;
		else if (en_low_done)
			state_r <= ST_OFF;
		else begin
			unique case (state_r)
				ST_OFF:     if (en_s) state_r <= ST_STARTUP;
				ST_STARTUP: if (hard_fault) state_r <= ST_LATCHED;
				            else if (blank_r == CW'(fault_sup_pkg::STARTUP_BLANK_CYCLES)) state_r <= ST_RUN;
				ST_RUN:     if (hard_fault) state_r <= ST_LATCHED;
				ST_LATCHED: state_r <= ST_LATCHED;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n || state_r != ST_STARTUP)
			blank_r <= '0;
		else if (blank_r != CW'(fault_sup_pkg::STARTUP_BLANK_CYCLES))
			blank_r <= blank_r + CW'(1);
	end

	// Grace timer counts switching cycles while 1X overcurrent persists
	always_ff @(posedge core_clk) begin
		if (!rst_n || !over1_s || state_r == ST_OFF)
			grace_r <= '0;
		else if (switch_cycle_tick && !grace_expired)
			grace_r <= grace_r + CW'(1);
	end

	// Cycle limit blanks the boost until the next switching cycle starts
	// A trip in the cycle of a tick wins, so the boost never restarts into a live trip
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			cyc_off_r <= 1'b0;
		else if (cyc_lim_s)
			cyc_off_r <= 1'b1;
		else if (switch_cycle_tick)
			cyc_off_r <= 1'b0;
	end

	logic active;
	// Outputs drop in the same cycle that a shutdown sends the state to off
	assign active = (state_r == ST_STARTUP || state_r == ST_RUN) && !sync_low_done && !hard_fault
		&& !en_low_done && !uv_lock_r;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			boost_enable          <= 1'b0;
			disconnect_on         <= 1'b0;
			disconnect_limit_mode <= 1'b0;
			sinks_enable          <= 1'b0;
			fault_n               <= 1'b1;
			low_power             <= 1'b1;
		end else begin
			boost_enable          <= active && !cyc_off_r && !cyc_lim_s;
			disconnect_on         <= active;
			disconnect_limit_mode <= active && over1_s;
			sinks_enable          <= active;
			// Flag is pulled low on a fault; 1X alone releases it when it clears
			fault_n               <= !(state_r == ST_LATCHED || hard_fault || (over1_s && state_r != ST_OFF));
			low_power             <= (state_r == ST_OFF);
		end
	end

	property p_latch_off;
		@(posedge core_clk) disable iff (!rst_n)
		(state_r == ST_RUN && sec_lim_s && !uv_lock_r && !en_low_done) |=> ##1 (!disconnect_on && !sinks_enable && !fault_n);
	endproperty
	a_latch_off: assert property (p_latch_off) else $error("secondary limit did not latch off");

	property p_2x_fast;
		@(posedge core_clk) disable iff (!rst_n)
		$rose(s2_r[4]) |-> ##[1:2] !boost_enable && !disconnect_on;
	endproperty
	a_2x_fast: assert property (p_2x_fast) else $error("2X shutdown too slow");

	property p_1x_flag;
		@(posedge core_clk) disable iff (!rst_n)
		(over1_s && state_r != ST_OFF) |=> !fault_n;
	endproperty
	a_1x_flag: assert property (p_1x_flag) else $error("1X did not raise fault flag");

	property p_grace_latch;
		@(posedge core_clk) disable iff (!rst_n)
		(grace_expired && state_r == ST_RUN && !uv_lock_r && !en_low_done) |=> state_r == ST_LATCHED;
	endproperty
	a_grace_latch: assert property (p_grace_latch) else $error("grace expiry did not latch");

	property p_sync_off;
		@(posedge core_clk) disable iff (!rst_n)
		sync_low_done |=> !disconnect_on && !sinks_enable && !boost_enable;
	endproperty
	a_sync_off: assert property (p_sync_off) else $error("sync shutdown ignored");

	property p_uv_clear;
		@(posedge core_clk) disable iff (!rst_n)
		uv_done |=> ##1 state_r == ST_OFF;
	endproperty
	a_uv_clear: assert property (p_uv_clear) else $error("undervoltage did not clear");

	property p_en_clear;
		@(posedge core_clk) disable iff (!rst_n)
		en_low_done |=> state_r == ST_OFF && !sinks_enable;
	endproperty
	a_en_clear: assert property (p_en_clear) else $error("enable low did not shut down");

	property p_cycle_limit;
		@(posedge core_clk) disable iff (!rst_n)
		(cyc_lim_s && !switch_cycle_tick && state_r == ST_RUN && !over1_s && !hard_fault) |=> ##1 !boost_enable && fault_n;
	endproperty
	a_cycle_limit: assert property (p_cycle_limit) else $error("cycle limit misbehaved");

	c_latched: cover property (@(posedge core_clk) disable iff (!rst_n) state_r == ST_LATCHED);
	c_grace:   cover property (@(posedge core_clk) disable iff (!rst_n) over1_s ##1 !over1_s && state_r == ST_RUN);
	c_release: cover property (@(posedge core_clk) disable iff (!rst_n) state_r == ST_LATCHED ##1 state_r == ST_OFF);
endmodule : led_driver_fault_supervisor

// *** bench/host_pin_model.sv ***
// Host controller model: drives the enable and sync pins of the fault supervisor.
// Assumes the bench sets the requests and times how long each is held, in core_clk cycles.
`timescale 1ns/1ps
module host_pin_model (
	input  wire logic core_clk,
	input  wire logic enable_req,
	input  wire logic kill_req,
	output logic      dim_enable_pin,
	output logic      freq_set_sync_pin
);
	// Pins move on falling edges only, clear of the sampling edge; reset covers the first cycle, before the first falling edge
	always @(negedge core_clk) begin
		dim_enable_pin    <= enable_req;
		freq_set_sync_pin <= !kill_req;
	end
endmodule : host_pin_model

// *** bench/led_driver_fault_supervisor_tb.sv ***
// Self-checking bench for the LED driver fault supervisor.
// Assumes host_pin_model drives the host pins; comparator levels are driven here at falling edges.
`timescale 1ns/1ps
module led_driver_fault_supervisor_tb;
	localparam int EN_LOW = 20;
	localparam int GRACE  = 8;
	logic core_clk, rst_n, enable_req, kill_req, dim_en, sync_pin;
	logic tick = 1'b0;
	logic cyc_lim, sec_lim, over_1x, over_2x, ovp, sup_ok, sense_ok, sup_low;
	logic boost, disc, lim_mode, sinks, fault_n, low_power;
	int   bad_count, check_count;
	int   cycles = 0;

	led_driver_fault_supervisor #(.EN_LOW_CYCLES(EN_LOW), .GRACE_CYCLES(GRACE)) i_led_driver_fault_supervisor (
		.core_clk(core_clk), .rst_n(rst_n), .switch_cycle_tick(tick), .dim_enable_pin(dim_en),
		.freq_set_sync_pin(sync_pin), .switch_cycle_current_limit(cyc_lim), .secondary_switch_limit(sec_lim),
		.input_over_1x(over_1x), .input_over_2x(over_2x), .secondary_overvoltage_threshold(ovp),
		.supply_above_rise(sup_ok), .sense_above_rise(sense_ok), .supply_below_fall(sup_low),
		.boost_enable(boost), .disconnect_on(disc), .disconnect_limit_mode(lim_mode),
		.sinks_enable(sinks), .fault_n(fault_n), .low_power(low_power));
	host_pin_model i_host_pin_model (.core_clk(core_clk), .enable_req(enable_req), .kill_req(kill_req),
		.dim_enable_pin(dim_en), .freq_set_sync_pin(sync_pin));

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// Switching cycle marker every 10 core cycles
	always @(negedge core_clk) begin
		cycles <= cycles + 1;
		tick   <= (cycles % 10) == 0;
	end
	// Whole run needs about 3300 cycles
	always @(posedge core_clk) begin
		if (cycles == 10000) begin
			bad_count++;
			final_report();
		end
	end

	task automatic check(input string what, input logic [4:0] seen, input logic [4:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : wait_cyc
	function automatic logic [4:0] outs();
		return {boost, disc, sinks, fault_n, lim_mode};
	endfunction : outs
	task automatic power_up();
		enable_req <= 1'b1;
		wait_cyc(100);
		check("run", outs(), 5'h1E);
	endtask : power_up
	// Long enable low is the only way out of a latched fault short of undervoltage
	task automatic release_latch();
		enable_req <= 1'b0;
		wait_cyc(EN_LOW + 8);
		check("released", outs(), 5'h02);
		check("low power", {4'h0, low_power}, 5'h01);
		power_up();
	endtask : release_latch
	task automatic cycle_limit();
		cyc_lim <= 1'b1;
		wait_cyc(4);
		check("cycle limit", outs(), 5'h0E);
		cyc_lim <= 1'b0;
		wait_cyc(15);
		check("cycle limit end", outs(), 5'h1E);
	endtask : cycle_limit
	task automatic latched_faults();
		for (int k = 0; k < 3; k++) begin
			{sec_lim, over_2x, ovp} <= 3'h4 >> k;
			wait_cyc(k == 1 ? 76 : 4);
			check("latch on", outs(), 5'h00);
			{sec_lim, over_2x, ovp} <= 3'h0;
			wait_cyc(10);
			check("latch held", outs(), 5'h00);
			release_latch();
		end
	endtask : latched_faults
	task automatic input_1x();
		over_1x <= 1'b1;
		wait_cyc(4);
		check("1x grace", outs(), 5'h1D);
		over_1x <= 1'b0;
		wait_cyc(5);
		check("1x cleared", outs(), 5'h1E);
		over_1x <= 1'b1;
		wait_cyc(GRACE * 10 + 25);
		check("1x expired", outs(), 5'h00);
		over_1x <= 1'b0;
		release_latch();
	endtask : input_1x
	task automatic sync_kill();
		kill_req <= 1'b1;
		wait_cyc(150);
		check("short sync low", outs(), 5'h1E);
		wait_cyc(40);
		check("sync shutdown", {boost, disc, sinks, 2'h0}, 5'h00);
		kill_req <= 1'b0;
		release_latch();
	endtask : sync_kill
	task automatic undervoltage();
		sup_low <= 1'b1;
		wait_cyc(600);
		check("supply glitch", outs(), 5'h1E);
		sup_low <= 1'b0;
		ovp     <= 1'b1;
		wait_cyc(5);
		ovp     <= 1'b0;
		sup_low <= 1'b1;
		{sup_ok, sense_ok} <= 2'h0;
		wait_cyc(1300);
		check("undervoltage", outs(), 5'h02);
		sup_low <= 1'b0;
		sup_ok  <= 1'b1;
		wait_cyc(100);
		check("sense still low", outs(), 5'h02);
		sense_ok <= 1'b1;
		wait_cyc(10);
		ovp      <= 1'b1;
		wait_cyc(10);
		ovp      <= 1'b0;
		check("startup blank", outs(), 5'h1E);
		power_up();
	endtask : undervoltage

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report

	initial begin
		bad_count = 0;
		check_count = 0;
		rst_n = 1'b0;
		enable_req = 1'b0;
		kill_req = 1'b0;
		{cyc_lim, sec_lim, over_1x, over_2x, ovp, sup_low} = 6'h00;
		{sup_ok, sense_ok} = 2'h3;
		wait_cyc(8);
		check("reset", outs(), 5'h02);
		rst_n <= 1'b1;
		power_up();
		cycle_limit();
		latched_faults();
		input_1x();
		sync_kill();
		undervoltage();
		final_report();
	end
endmodule : led_driver_fault_supervisor_tb
